//--- tmr_pkg.sv
/*
  Package for the 8-bit timer compare/waveform block: register offsets,
  field positions, reset values, mode and output-action codes, carrier structs.
  Assumes a 32-bit APB slave with byte addresses, one register per word.
*/
package tmr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FORCE = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMPA = 8'h0C;
  localparam logic [7:0] OFF_CMPB = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_PORT = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMPA_BIT = 1;
  localparam int PORT_DIR_LSB = 0;
  localparam int PORT_VAL_LSB = 2;
  localparam int PORT_OC_LSB = 4;

  // ----------------------------------------------------------------
  // reset values and counter extremes
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hFF;
  localparam int PRESC_W = 10;

  // ----------------------------------------------------------------
  // waveform modes and compare output actions
  // ----------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [2:0] wgm;
  } tmr_ctrl_s;

  typedef struct packed {
    logic out;
    logic oe_n;
  } tmr_pin_s;

endpackage

//--- tmr_compare_waveform.sv
/*
  8-bit timer/counter with two compare channels, prescaler, counter modes
  normal, clear-on-match and fast PWM, compare output state and pin override.
  Assumes an APB master on pclk and a port pad that resolves value and
  active-low enable; interrupt service acknowledges arrive as pclk pulses.
*/
`timescale 1ns/1ps

// Behaviour
// - counter write blocks all compare matches during the next timer tick
// - output state keeps its value when the waveform mode changes
// - output mode bits unbuffered; new setting acts at next match
// - nonzero output mode puts the output state on the pin
// - pin shows output state only while direction bit selects output
// - output mode zero leaves output state unchanged on match
// - force strobe in non-PWM modes applies the action immediately
// - count sequence depends only on waveform mode
// - mode 0 always increments and wraps from FF to 00
// - mode 0 sets overflow flag as counter becomes zero
// - mode 2 clears counter on match with compare A
// - mode 2 compare A unbuffered; missed top means wrap through FF
// - mode 2 raises compare flag A at each top
// - mode 2 output mode 1 toggles output A on each match
// - mode 2 sets overflow flag when counter passes FF to 00
// - modes 3 and 7 count single-slope to FF or compare A
// - fast PWM non-inverting clears on match, sets at bottom; inverting opposite
// - prescaler divides by 1, 8, 32, 64, 128, 256 or 1024
// - compare flag set one tick after match; cleared by one or service
// - fast PWM output mode 2 non-inverted, 3 inverted
module tmr_compare_waveform #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // interrupt service acknowledges
  input wire logic ovf_serviced,
  input wire logic cmp_a_serviced,
  input wire logic cmp_b_serviced,
  // compare output pins
  output tmr_pkg::tmr_pin_s pin_a,
  output tmr_pkg::tmr_pin_s pin_b
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must be 5..32");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    return a == tmr_pkg::OFF_CTRL || a == tmr_pkg::OFF_FORCE || a == tmr_pkg::OFF_COUNT ||
           a == tmr_pkg::OFF_CMPA || a == tmr_pkg::OFF_CMPB || a == tmr_pkg::OFF_FLAGS ||
           a == tmr_pkg::OFF_PORT;
  endfunction

  // next output state for one channel
  function automatic logic oc_next(input logic oc, input logic [1:0] com, input logic fast,
                                   input logic match, input logic bottom, input logic tog_ok);
    logic r;
    r = oc;
    if (!fast) begin
      if (match) begin
        case (com)
          tmr_pkg::COM_TOGGLE: r = ~oc;
          tmr_pkg::COM_CLEAR: r = 1'b0;
          tmr_pkg::COM_SET: r = 1'b1;
          default: r = oc;
        endcase
      end
    end else begin
      // bottom wins so a compare at top still gives a steady level
      case (com)
        tmr_pkg::COM_CLEAR: r = bottom ? 1'b1 : (match ? 1'b0 : oc);
        tmr_pkg::COM_SET: r = bottom ? 1'b0 : (match ? 1'b1 : oc);
        tmr_pkg::COM_TOGGLE: r = (match && tog_ok) ? ~oc : oc;
        default: r = oc;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] addr;
  logic wr;
  logic rd_setup;
  logic cnt_wr;
  assign addr = 8'(paddr);
  assign wr = psel & penable & pwrite & addr_ok(addr);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign cnt_wr = wr & (addr == tmr_pkg::OFF_COUNT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(addr);

  // ----------------------------------------------------------------
  // control and port registers
  // ----------------------------------------------------------------
  tmr_pkg::tmr_ctrl_s ctrl;
  logic [1:0] dir;
  logic [1:0] port_val;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else if (wr && addr == tmr_pkg::OFF_CTRL) begin
      // output mode takes effect at once, no shadow copy
      ctrl.wgm <= pwdata[tmr_pkg::CTRL_WGM_LSB +: 3];
      ctrl.com_a <= pwdata[tmr_pkg::CTRL_COMA_LSB +: 2];
      ctrl.com_b <= pwdata[tmr_pkg::CTRL_COMB_LSB +: 2];
      ctrl.clk_sel <= pwdata[tmr_pkg::CTRL_CS_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= 2'h0;
      port_val <= 2'h0;
    end else if (wr && addr == tmr_pkg::OFF_PORT) begin
      dir <= pwdata[tmr_pkg::PORT_DIR_LSB +: 2];
      port_val <= pwdata[tmr_pkg::PORT_VAL_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [tmr_pkg::PRESC_W-1:0] presc;
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else if (ctrl.clk_sel == 3'h0) begin
      presc <= '0;
    end else begin
      presc <= presc + tmr_pkg::PRESC_W'(1);
    end
  end

  always_comb begin
    case (ctrl.clk_sel)
      3'h1: tick = 1'b1;
      3'h2: tick = &presc[2:0];
      3'h3: tick = &presc[4:0];
      3'h4: tick = &presc[5:0];
      3'h5: tick = &presc[6:0];
      3'h6: tick = &presc[7:0];
      3'h7: tick = &presc[9:0];
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [7:0] cnt;
  logic [7:0] cmp_buf [2];
  logic [7:0] cmp_act [2];
  logic block;
  logic fast;
  logic clear_on_match_mode;
  logic [7:0] top;
  logic [1:0] match;
  logic cnt_clear;
  logic bottom_ev;
  logic ovf_ev;

  // sequence chosen by mode bits only, output mode not involved
  assign fast = ctrl.wgm == tmr_pkg::WGM_FAST_MAX || ctrl.wgm == tmr_pkg::WGM_FAST_CMPA;
  assign clear_on_match_mode = ctrl.wgm == tmr_pkg::WGM_CTC;
  assign top = (ctrl.wgm == tmr_pkg::WGM_FAST_CMPA) ? cmp_act[0] : tmr_pkg::MAX;
  // a pending counter write hides every match until the next tick
  assign match[0] = (cnt == cmp_act[0]) & ~block;
  assign match[1] = (cnt == cmp_act[1]) & ~block;
  assign cnt_clear = (clear_on_match_mode & match[0]) | (fast & cnt == top);
  assign bottom_ev = tick & ~cnt_wr & fast & cnt == top;
  // overflow: max to zero in normal and ctc, at top in fast pwm
  assign ovf_ev = tick & ~cnt_wr & (fast ? cnt == top : cnt == tmr_pkg::MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= tmr_pkg::CNT_RST;
    end else if (cnt_wr) begin
      cnt <= pwdata[7:0];
    end else if (tick) begin
      // a ctc top below the count is missed and the count wraps
      cnt <= cnt_clear ? tmr_pkg::BOTTOM : cnt + 8'h01;
    end
  end

  // held even with the clock stopped, released by the first tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block <= 1'b0;
    end else if (cnt_wr) begin
      block <= 1'b1;
    end else if (tick) begin
      block <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare registers: direct in non-pwm, reloaded at bottom in fast pwm
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_buf[0] <= tmr_pkg::CMP_RST;
      cmp_buf[1] <= tmr_pkg::CMP_RST;
    end else if (wr && addr == tmr_pkg::OFF_CMPA) begin
      cmp_buf[0] <= pwdata[7:0];
    end else if (wr && addr == tmr_pkg::OFF_CMPB) begin
      cmp_buf[1] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_act[0] <= tmr_pkg::CMP_RST;
      cmp_act[1] <= tmr_pkg::CMP_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!fast) begin
          // unbuffered: a write lands in the comparator at once
          cmp_act[i] <= (wr && addr == (i == 0 ? tmr_pkg::OFF_CMPA : tmr_pkg::OFF_CMPB)) ?
                        pwdata[7:0] : cmp_buf[i];
        end else if (bottom_ev) begin
          cmp_act[i] <= cmp_buf[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic [1:0] pend;
  logic [1:0] cmp_flag;
  logic ovf_flag;
  logic flag_wr;
  logic [1:0] serviced;
  assign flag_wr = wr & (addr == tmr_pkg::OFF_FLAGS);
  assign serviced = {cmp_b_serviced, cmp_a_serviced};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 2'h0;
    end else if (tick) begin
      pend <= match;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_flag <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // set one tick after the match, set beats clear
        cmp_flag[i] <= (tick & pend[i]) |
                       (cmp_flag[i] & ~(flag_wr & pwdata[tmr_pkg::FLAG_CMPA_BIT + i]) &
                        ~serviced[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag <= 1'b0;
    end else begin
      ovf_flag <= ovf_ev |
                  (ovf_flag & ~(flag_wr & pwdata[tmr_pkg::FLAG_OVF_BIT]) & ~ovf_serviced);
    end
  end

  // ----------------------------------------------------------------
  // output state and pins
  // ----------------------------------------------------------------
  logic [1:0] oc;
  logic [1:0] force_ev;
  logic [1:0] com [2];
  assign com[0] = ctrl.com_a;
  assign com[1] = ctrl.com_b;
  assign force_ev = {2{wr & addr == tmr_pkg::OFF_FORCE & ~fast}} & pwdata[1:0];

  // no reset on a mode change: state only moves on force or tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (force_ev[i]) begin
          // acts like a match but sets no flag and leaves the counter
          oc[i] <= oc_next(oc[i], com[i], 1'b0, 1'b1, 1'b0, 1'b0);
        end else if (tick) begin
          // com zero keeps state; toggle/clear/set or pwm polarity
          oc[i] <= oc_next(oc[i], com[i], fast, match[i], bottom_ev,
                           i == 0 && ctrl.wgm == tmr_pkg::WGM_FAST_CMPA);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a <= '{out: 1'b0, oe_n: 1'b1};
      pin_b <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      // override independent of mode; direction stays with the port
      pin_a.out <= (ctrl.com_a != tmr_pkg::COM_NONE) ? oc[0] : port_val[0];
      pin_b.out <= (ctrl.com_b != tmr_pkg::COM_NONE) ? oc[1] : port_val[1];
      pin_a.oe_n <= ~dir[0];
      pin_b.oe_n <= ~dir[1];
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      case (addr)
        tmr_pkg::OFF_CTRL: prdata <= 32'({ctrl.clk_sel, ctrl.com_b, ctrl.com_a, 1'b0, ctrl.wgm});
        tmr_pkg::OFF_COUNT: prdata <= 32'(cnt);
        tmr_pkg::OFF_CMPA: prdata <= 32'(cmp_buf[0]);
        tmr_pkg::OFF_CMPB: prdata <= 32'(cmp_buf[1]);
        tmr_pkg::OFF_FLAGS: prdata <= 32'({cmp_flag, ovf_flag});
        tmr_pkg::OFF_PORT: prdata <= 32'({oc, port_val, dir});
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_block_match: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> (match == 2'h0) until (tick && !cnt_wr))
    else $error("compare match seen while counter write block pending");

  a_mode_keeps_state: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && addr == tmr_pkg::OFF_CTRL && !tick) |=> oc == $past(oc))
    else $error("output state changed on a control write");

  a_pin_override: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.com_a != tmr_pkg::COM_NONE |=> pin_a.out == $past(oc[0]))
    else $error("pin A not driven from output state");

  a_pin_direction: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_a.oe_n == !$past(dir[0]))
    else $error("pin A enable does not follow direction bit");

  a_com_zero_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.com_a == tmr_pkg::COM_NONE && !force_ev[0]) |=> $stable(oc[0]))
    else $error("output A changed with mode zero");

  a_force_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (force_ev[0] && ctrl.com_a == tmr_pkg::COM_TOGGLE) |=> oc[0] != $past(oc[0]))
    else $error("force strobe did not toggle output A");

  a_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !cnt_wr && ctrl.wgm == tmr_pkg::WGM_NORMAL && cnt == tmr_pkg::MAX)
    |=> cnt == tmr_pkg::BOTTOM && ovf_flag)
    else $error("normal mode wrap or overflow wrong");

  a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !cnt_wr && clear_on_match_mode && match[0]) |=> cnt == tmr_pkg::BOTTOM)
    else $error("ctc did not clear counter on match");

  a_match_pend: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> pend == $past(match))
    else $error("match not captured on timer tick");

  a_flag_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && pend[0]) |=> cmp_flag[0])
    else $error("compare flag A not set one tick after match");

  a_fast_noninv: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && fast && ctrl.com_a == tmr_pkg::COM_CLEAR && !force_ev[0])
    |=> oc[0] == ($past(bottom_ev) ? 1'b1 : ($past(match[0]) ? 1'b0 : $past(oc[0]))))
    else $error("fast pwm non-inverting output wrong");

endmodule // tmr_compare_waveform

//--- tmr_pad_model.sv
/*
  Port pad seen from outside the timer: resolves one compare output pin.
  Assumes the pin struct of tmr_pkg; the board holds a pull-up on the pad.
*/
`timescale 1ns/1ps

module tmr_pad_model (
  // from the timer
  input wire tmr_pkg::tmr_pin_s pin,
  // resolved pad level
  output logic pad
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  // released pad floats to the pull-up, never to the last driven value
  assign pad = pin.oe_n ? 1'b1 : pin.out;
endmodule // tmr_pad_model

//--- testbench.sv
/*
  Self-checking bench for the timer compare/waveform block over APB.
  Assumes the register map of tmr_pkg and zero wait states being possible.
*/
`timescale 1ns/1ps

module testbench;
  typedef struct {logic [31:0] exp; logic [31:0] mask; bit le;} tmr_note_s;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, ovf_serviced, cmp_a_serviced, cmp_b_serviced;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, res, q;
  logic pready, pslverr, last_err, pad_a, pad_b;
  tmr_pkg::tmr_pin_s pin_a, pin_b;
  tmr_note_s notes[$];
  logic [31:0] rnd = 32'd28;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int nd[6] = '{8, 32, 64, 128, 256, 1024};
  event res_ev;

  tmr_compare_waveform #(.ADDR_W(8)) i_tmr_compare_waveform (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ovf_serviced(ovf_serviced), .cmp_a_serviced(cmp_a_serviced),
    .cmp_b_serviced(cmp_b_serviced), .pin_a(pin_a), .pin_b(pin_b));
  tmr_pad_model i_tmr_pad_model (.pin(pin_a), .pad(pad_a));
  tmr_pad_model i_tmr_pad_model_b (.pin(pin_b), .pad(pad_b));

  always #50 pclk = ~pclk;

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic note(input logic [31:0] e, input logic [31:0] m, input bit le);
    notes.push_back('{e, m, le});
  endtask

  // one result per edge so the watcher never misses one
  task automatic post(input logic [31:0] v);
    res = v;
    -> res_ev;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input bit le);
    note(e, m, le);
    apb(1'b0, a, 32'h0);
    post(q);
  endtask

  task automatic pin_chk(input logic [1:0] e);
    @(posedge pclk);
    note({30'h0, e}, 32'h3, 0);
    post({30'h0, pin_a.oe_n, pad_a});
  endtask

  task automatic svc(input logic o, input logic a, input logic b);
    ovf_serviced <= o;
    cmp_a_serviced <= a;
    cmp_b_serviced <= b;
    @(posedge pclk);
    ovf_serviced <= 1'b0;
    cmp_a_serviced <= 1'b0;
    cmp_b_serviced <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] w, input logic [1:0] ca,
                                      input logic [2:0] cs);
    ctl = (32'(cs) << tmr_pkg::CTRL_CS_LSB) | (32'(ca) << tmr_pkg::CTRL_COMA_LSB) | 32'(w);
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic run(input logic [31:0] go, input logic [31:0] stop, input int n);
    wr(tmr_pkg::OFF_CTRL, go);
    repeat (n) @(posedge pclk);
    wr(tmr_pkg::OFF_CTRL, stop);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // result watcher and hang guard
  // ----------------------------------------------------------------
  always @(res_ev) begin
    tmr_note_s n;
    n = notes.pop_front();
    n_tests++;
    if (n.le ? (((res & n.mask) <= n.exp) !== 1'b1) : ((res & n.mask) !== n.exp)) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, res & n.mask, n.exp);
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] act[5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
    logic st[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0] md[2] = '{tmr_pkg::WGM_CTC, tmr_pkg::WGM_FAST_CMPA};
    {presetn, psel, penable, pwrite, ovf_serviced, cmp_a_serviced, cmp_b_serviced} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(tmr_pkg::OFF_CTRL, 32'h0, 32'hFFFFFFFF, 0);
    pin_chk(2'h3);
    note(32'h0, 32'hFFFFFFFF, 0);
    note(32'h1, 32'h1, 0);
    apb(1'b0, 8'h1C, 32'h0);
    post(q);
    post({31'h0, last_err});
    wr(tmr_pkg::OFF_PORT, 32'h0);
    // actions applied by the strobe, mode flipping between entries
    for (int i = 0; i < 5; i++) begin
      wr(tmr_pkg::OFF_CTRL, ctl(i[0] ? tmr_pkg::WGM_CTC : tmr_pkg::WGM_NORMAL, act[i], 3'h0));
      wr(tmr_pkg::OFF_FORCE, 32'h1);
      rd(tmr_pkg::OFF_PORT, 32'(st[i]) << 4, 32'h10, 0);
    end
    wr(tmr_pkg::OFF_CTRL, ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::COM_SET, 3'h0));
    wr(tmr_pkg::OFF_FORCE, 32'h1);
    pin_chk(2'h3);
    wr(tmr_pkg::OFF_PORT, 32'h1);
    pin_chk(2'h1);
    wr(tmr_pkg::OFF_CTRL, ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::COM_NONE, 3'h0));
    pin_chk(2'h0);
    // counter written equal to both compares: first tick must not match
    wr(tmr_pkg::OFF_CMPA, 32'h5);
    wr(tmr_pkg::OFF_CMPB, 32'h5);
    wr(tmr_pkg::OFF_COUNT, 32'h5);
    wr(tmr_pkg::OFF_FLAGS, 32'h7);
    run(ctl(3'h0, 2'h0, 3'h1), 32'h0, 3);
    rd(tmr_pkg::OFF_FLAGS, 32'h0, 32'h6, 0);
    // wrap through MAX with compare B at zero
    wr(tmr_pkg::OFF_CMPA, 32'h80);
    wr(tmr_pkg::OFF_CMPB, 32'h0);
    wr(tmr_pkg::OFF_COUNT, 32'hFE);
    wr(tmr_pkg::OFF_FLAGS, 32'h7);
    run(ctl(3'h0, 2'h0, 3'h1), 32'h0, 4);
    rd(tmr_pkg::OFF_FLAGS, 32'h5, 32'h7, 0);
    rd(tmr_pkg::OFF_COUNT, 32'h0F, 32'hFF, 1);
    svc(1'b1, 1'b0, 1'b1);
    rd(tmr_pkg::OFF_FLAGS, 32'h0, 32'h7, 0);
    // compare A as top: clear-on-match and fast PWM to compare A
    for (int i = 0; i < 2; i++) begin
      wr(tmr_pkg::OFF_CTRL, 32'h0);
      wr(tmr_pkg::OFF_CMPA, 32'h8);
      wr(tmr_pkg::OFF_COUNT, 32'h0);
      wr(tmr_pkg::OFF_FLAGS, 32'h7);
      run(ctl(md[i], 2'h0, 3'h1), ctl(md[i], 2'h0, 3'h0), 40);
      rd(tmr_pkg::OFF_COUNT, 32'h08, 32'hFF, 1);
      rd(tmr_pkg::OFF_FLAGS, i ? 32'h3 : 32'h2, 32'h3, 0);
      svc(1'b0, 1'b1, 1'b0);
      rd(tmr_pkg::OFF_FLAGS, 32'h0, 32'h2, 0);
    end
    // fast PWM to MAX, both polarities; first run stops short of compare, second runs past it
    for (int c = 2; c < 4; c++) begin
      wr(tmr_pkg::OFF_CTRL, 32'h0);
      wr(tmr_pkg::OFF_CMPA, 32'h20);
      wr(tmr_pkg::OFF_COUNT, 32'hF0);
      run(ctl(tmr_pkg::WGM_FAST_MAX, c[1:0], 3'h1), ctl(tmr_pkg::WGM_FAST_MAX, c[1:0], 3'h0), 14);
      rd(tmr_pkg::OFF_PORT, c == 2 ? 32'h10 : 32'h0, 32'h10, 0);
      run(ctl(tmr_pkg::WGM_FAST_MAX, c[1:0], 3'h1), ctl(tmr_pkg::WGM_FAST_MAX, c[1:0], 3'h0), 40);
      rd(tmr_pkg::OFF_PORT, c == 2 ? 32'h0 : 32'h10, 32'h10, 0);
    end
    // three ticks at each divider from 8 to 1024
    for (int k = 0; k < 6; k++) begin
      wr(tmr_pkg::OFF_CTRL, 32'h0);
      wr(tmr_pkg::OFF_COUNT, 32'h0);
      run(ctl(3'h0, 2'h0, 3'(k + 2)), 32'h0, 3 * nd[k] - 3);
      rd(tmr_pkg::OFF_COUNT, 32'h2, 32'hFFFFFFFE, 0);
    end
    for (int r = 0; r < 4; r++) begin
      rnd = xs(rnd);
      wr(tmr_pkg::OFF_CMPB, rnd);
      rd(tmr_pkg::OFF_CMPB, {24'h0, rnd[7:0]}, 32'hFFFFFFFF, 0);
      wr(tmr_pkg::OFF_COUNT, rnd >> 8);
      rd(tmr_pkg::OFF_COUNT, {24'h0, rnd[15:8]}, 32'hFFFFFFFF, 0);
    end
    complete_run();
  end
endmodule // testbench
